// ===== hdl/e2e_engine.sv
// protection field engine: axi4-lite registers and byte stream path
`timescale 1ns/1ps
module e2e_engine
  import e2e_pkg::*;
(
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic CE_I,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  output logic [1:0] S_AXI_BRESP,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  input wire logic IN_VALID_I,
  output logic IN_READY_O,
  input wire logic [7:0] IN_DATA_I,
  output logic IN_META_O,
  output logic OUT_VALID_O,
  input wire logic OUT_READY_I,
  output logic [7:0] OUT_DATA_O,
  output logic OUT_META_O,
  output logic BUSY_O
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_q;
  logic rst_n;

  // assert at once, release two edges later
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_q <= 2'b00;
    end else begin
      rst_q <= {rst_q[0], 1'b1};
    end
  end
  assign rst_n = rst_q[1];

  // ----------------------------------------------------------------
  // slot decode
  // ----------------------------------------------------------------
  e2e_st_t s_r, s_nxt;
  logic prot, gen, ins, strip, chkpi, in_md, is_pi, covered, last_slot;
  logic run, can_out, need_in, need_out, adv, eval, skip, meta_flag;
  logic aw_hs, w_hs, ar_hs, wr_go, start_req;
  logic [15:0] md16, m, pi_base, crc_step;
  logic [2:0] k;
  logic [63:0] pi_word, gen_word, gen_sh;
  logic [7:0] gen_b;
  logic [31:0] wr_old, wr_new;

  function automatic logic [31:0] reg_word(input e2e_st_t s,
                                           input logic [7:0] a);
    logic [31:0] w;
    w = 32'h00000000;
    case (a)
      OFS_CTRL: begin
        w[CTRL_WR_BIT] = s.cfg.wr;
        w[CTRL_ACT_BIT] = s.cfg.act;
        w[CTRL_CHK_LSB +: 3] = s.cfg.chk;
      end
      OFS_FMT: begin
        w[FMT_TYPE_LSB +: 2] = s.cfg.ptype;
        w[FMT_PIFIRST_BIT] = s.cfg.pi_first;
        w[FMT_SEP_BIT] = s.cfg.sep;
        w[FMT_MD_LSB +: 8] = s.cfg.md;
      end
      OFS_TAGS: w = {s.cfg.mask, s.cfg.app};
      OFS_REF: w = s.cfg.ref0;
      OFS_COUNT: w[15:0] = s.cfg.nblk;
      OFS_STAT: begin
        w[STAT_BUSY_BIT] = s.st != E2E_IDLE;
        w[STAT_DONE_BIT] = s.done;
        w[STAT_ERR_LSB +: 2] = s.err;
        w[STAT_LEFT_LSB +: 16] = s.left;
      end
      OFS_CURREF: w = s.refx;
      default: w = 32'h00000000;
    endcase
    return w;
  endfunction

  // mode decode from the namespace format and command
  assign md16 = {8'h00, s_r.cfg.md};
  assign prot = s_r.cfg.ptype != PT_NONE;
  assign gen = prot && s_r.cfg.wr && s_r.cfg.act;
  assign ins = gen && (md16 == PI_LEN);
  assign strip = prot && !s_r.cfg.wr && s_r.cfg.act && (md16 == PI_LEN);
  assign chkpi = prot && !gen;

  // position of the current slot in the extended block
  assign in_md = s_r.pos >= BLK_LEN;
  assign m = s_r.pos - BLK_LEN;
  assign pi_base = s_r.cfg.pi_first ? 16'h0000 : md16 - PI_LEN;
  assign is_pi = prot && in_md && (m >= pi_base) && (m < pi_base + PI_LEN);
  assign k = m[2:0] - pi_base[2:0];
  // leading field: data only; trailing field: also metadata before it
  assign covered = !in_md || (!s_r.cfg.pi_first && m < pi_base);
  assign last_slot = s_r.pos == BLK_LEN + md16 - 16'h0001;
  assign meta_flag = s_r.cfg.sep && in_md;

  // stream handshake, one byte per slot
  assign run = CE_I && (s_r.st == E2E_RUN);
  assign can_out = !s_r.ovalid || OUT_READY_I;
  assign need_in = !(ins && is_pi);
  assign need_out = !(strip && is_pi);
  assign adv = run && (!need_in || IN_VALID_I) && (!need_out || can_out);

  // field assembly, msb first within each tag
  assign pi_word = {s_r.pi_sh, IN_DATA_I};
  assign skip = pi_skip(s_r.cfg.ptype, pi_word[47:32], pi_word[31:0]);
  assign eval = adv && chkpi && is_pi && (k == 3'h7);
  // generated field: guard, command tag, running reference tag
  assign gen_word = {s_r.crc, s_r.cfg.app, s_r.refx};
  assign gen_sh = gen_word << {k, 3'b000};
  assign gen_b = gen_sh[63:56];

  e2e_crc16_step u_crc (
    .crc_i(s_r.crc),
    .data_i(IN_DATA_I),
    .crc_o(crc_step)
  );

  // ----------------------------------------------------------------
  // bus handshakes
  // ----------------------------------------------------------------
  // readies drop with the clock enable so no beat is lost while frozen
  assign S_AXI_AWREADY = CE_I && !s_r.aw_got && !s_r.bvalid;
  assign S_AXI_WREADY = CE_I && !s_r.w_got && !s_r.bvalid;
  assign S_AXI_ARREADY = CE_I && !s_r.rvalid;
  assign S_AXI_BVALID = CE_I && s_r.bvalid;
  assign S_AXI_RVALID = CE_I && s_r.rvalid;
  assign S_AXI_BRESP = s_r.bresp;
  assign S_AXI_RDATA = s_r.rdata;
  assign S_AXI_RRESP = s_r.rresp;
  assign aw_hs = S_AXI_AWVALID && S_AXI_AWREADY;
  assign w_hs = S_AXI_WVALID && S_AXI_WREADY;
  assign ar_hs = S_AXI_ARVALID && S_AXI_ARREADY;
  assign wr_go = CE_I && s_r.aw_got && s_r.w_got && !s_r.bvalid;
  assign wr_old = reg_word(s_r, s_r.awaddr);
  assign wr_new = wr32(wr_old, s_r.wdata, s_r.wstrb);
  assign start_req = wr_go && (s_r.awaddr == OFS_CTRL) &&
                     wr_new[CTRL_START_BIT] && (s_r.st == E2E_IDLE);

  // stream and status outputs
  assign IN_READY_O = adv && need_in;
  assign IN_META_O = meta_flag;
  assign OUT_VALID_O = CE_I && s_r.ovalid;
  assign OUT_DATA_O = s_r.obyte.data;
  assign OUT_META_O = s_r.obyte.meta;
  assign BUSY_O = s_r.st != E2E_IDLE;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_nxt = s_r;
    if (aw_hs) begin
      s_nxt.aw_got = 1'b1;
      s_nxt.awaddr = S_AXI_AWADDR;
    end
    if (w_hs) begin
      s_nxt.w_got = 1'b1;
      s_nxt.wdata = S_AXI_WDATA;
      s_nxt.wstrb = S_AXI_WSTRB;
    end
    if (S_AXI_BVALID && S_AXI_BREADY) begin
      s_nxt.bvalid = 1'b0;
    end
    if (S_AXI_RVALID && S_AXI_RREADY) begin
      s_nxt.rvalid = 1'b0;
    end
    if (ar_hs) begin
      s_nxt.rvalid = 1'b1;
      s_nxt.rdata = reg_word(s_r, S_AXI_ARADDR);
      s_nxt.rresp = addr_ok(S_AXI_ARADDR) ? RESP_OKAY : RESP_SLVERR;
    end
    // config is held while busy, a mid-command change would skew slots
    if (wr_go) begin
      s_nxt.aw_got = 1'b0;
      s_nxt.w_got = 1'b0;
      s_nxt.bvalid = 1'b1;
      s_nxt.bresp = addr_ok(s_r.awaddr) ? RESP_OKAY : RESP_SLVERR;
      if (s_r.st == E2E_IDLE) begin
        case (s_r.awaddr)
          OFS_CTRL: begin
            s_nxt.cfg.wr = wr_new[CTRL_WR_BIT];
            s_nxt.cfg.act = wr_new[CTRL_ACT_BIT];
            s_nxt.cfg.chk = wr_new[CTRL_CHK_LSB +: 3];
          end
          OFS_FMT: begin
            s_nxt.cfg.ptype = wr_new[FMT_TYPE_LSB +: 2];
            s_nxt.cfg.pi_first = wr_new[FMT_PIFIRST_BIT];
            s_nxt.cfg.sep = wr_new[FMT_SEP_BIT];
            s_nxt.cfg.md = wr_new[FMT_MD_LSB +: 8];
          end
          OFS_TAGS: begin
            s_nxt.cfg.app = wr_new[15:0];
            s_nxt.cfg.mask = wr_new[31:16];
          end
          OFS_REF: s_nxt.cfg.ref0 = wr_new;
          OFS_COUNT: s_nxt.cfg.nblk = wr_new[15:0];
          default: s_nxt.cfg = s_r.cfg;
        endcase
      end
    end
    // output register drains independently of slot progress
    if (s_r.ovalid && OUT_READY_I && CE_I) begin
      s_nxt.ovalid = 1'b0;
    end
    case (s_r.st)
      E2E_IDLE: begin
        if (start_req) begin
          s_nxt.pos = 16'h0000;
          s_nxt.crc = CRC_INIT;
          s_nxt.refx = s_r.cfg.ref0;
          s_nxt.left = s_r.cfg.nblk;
          s_nxt.err = ERR_NONE;
          s_nxt.done = 1'b0;
          s_nxt.st = (s_r.cfg.nblk == 16'h0000) ? E2E_DONE : E2E_RUN;
        end
      end
      E2E_RUN: begin
        if (adv) begin
          if (need_out) begin
            s_nxt.ovalid = 1'b1;
            s_nxt.obyte.meta = meta_flag;
            // generated bytes replace or fill the field slot
            s_nxt.obyte.data = (gen && is_pi) ? gen_b : IN_DATA_I;
          end
          if (covered) begin
            s_nxt.crc = crc_step;
          end
          if (is_pi) begin
            s_nxt.pi_sh = pi_word[55:0];
          end
          // first failing check wins, later blocks cannot overwrite it
          if (eval && !skip && s_r.err == ERR_NONE) begin
            if (s_r.cfg.chk[2] && pi_word[63:48] != s_r.crc) begin
              s_nxt.err = ERR_GUARD;
            end else if (s_r.cfg.chk[1] &&
                         ((pi_word[47:32] ^ s_r.cfg.app) &
                          s_r.cfg.mask) != 16'h0000) begin
              s_nxt.err = ERR_APP;
            end else if (s_r.cfg.chk[0] && pi_word[31:0] != s_r.refx) begin
              s_nxt.err = ERR_REF;
            end
          end
          if (last_slot) begin
            s_nxt.pos = 16'h0000;
            s_nxt.crc = CRC_INIT;
            if (s_r.cfg.ptype != PT_TYPE3) begin
              s_nxt.refx = s_r.refx + 32'h00000001;
            end
            s_nxt.left = s_r.left - 16'h0001;
            if (s_r.left == 16'h0001) begin
              s_nxt.st = E2E_DRAIN;
            end
          end else begin
            s_nxt.pos = s_r.pos + 16'h0001;
          end
        end
      end
      E2E_DRAIN: begin
        // done only once the last byte has left the output register
        if (!s_r.ovalid) begin
          s_nxt.st = E2E_DONE;
        end
      end
      E2E_DONE: begin
        s_nxt.done = 1'b1;
        s_nxt.st = E2E_IDLE;
      end
      default: s_nxt.st = E2E_IDLE;
    endcase
  end

  // state register, frozen while the clock enable is low
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= ST_RST;
    end else if (CE_I) begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I);
  endclocking
  default disable iff (!rst_n);

  sequence s_field_end;
    CE_I && eval && !skip && s_r.err == ERR_NONE;
  endsequence
  sequence s_blk_end;
    CE_I && adv && last_slot;
  endsequence

  chk_guard_flag: assert property (
    s_field_end ##0 s_r.cfg.chk[2] && pi_word[63:48] != s_r.crc
    |=> s_r.err == ERR_GUARD)
    else $error("guard miscompare not reported");
  chk_app_masked: assert property (
    s_field_end ##0 !s_r.cfg.chk[2] && s_r.cfg.chk[1] &&
    ((pi_word[47:32] ^ s_r.cfg.app) & s_r.cfg.mask) != 16'h0000
    |=> s_r.err == ERR_APP)
    else $error("app tag miscompare not reported");
  chk_skip_all: assert property (
    CE_I && eval && skip |=> $stable(s_r.err))
    else $error("check ran on disabled field");
  chk_ref_step: assert property (
    s_blk_end ##0 s_r.cfg.ptype != PT_TYPE3
    |=> s_r.refx == $past(s_r.refx) + 32'h00000001)
    else $error("ref tag did not step");
  chk_ref_fixed: assert property (
    s_blk_end ##0 s_r.cfg.ptype == PT_TYPE3 |=> $stable(s_r.refx))
    else $error("type 3 ref tag moved");
  chk_ins_noinput: assert property (
    ins && is_pi |-> !IN_READY_O)
    else $error("input taken during inserted field");
  chk_strip_field: assert property (
    CE_I && adv && strip && is_pi && !s_r.ovalid |=> !s_r.ovalid)
    else $error("stripped field reached output");
  chk_gen_byte: assert property (
    CE_I && adv && gen && is_pi |=> s_r.obyte.data == $past(gen_b))
    else $error("generated field byte wrong");
  chk_pass_byte: assert property (
    CE_I && adv && !prot
    |=> s_r.ovalid && s_r.obyte.data == $past(IN_DATA_I))
    else $error("unprotected byte altered");
  chk_crc_hold: assert property (
    CE_I && adv && !covered && !last_slot |=> $stable(s_r.crc))
    else $error("crc moved on uncovered byte");
  chk_done_flag: assert property (
    CE_I && s_r.st == E2E_DONE |=> s_r.done && s_r.st == E2E_IDLE)
    else $error("completion not flagged");

endmodule

// ===== hdl/e2e_pkg.sv
// shared constants, types and helpers of the protection field engine
// What this block does
// - protection field is the first or last eight metadata bytes
// - field leading, metadata above eight: guard covers block data only
// - field trailing: guard also covers metadata bytes before the field
// - guard bytes 0-1, app tag 2-3, ref tag 4-7, msb first
// - guard is a 16-bit crc over block data
// - no ip checksum guard, crc only
// - app tag is compared under the mask, and all ones disables checks (type 3 also needs ref tag all ones)
// - protection type 1, 2 or 3 fixed by format, readable by host
// - metadata travels appended to the block or in a separate buffer
// - unprotected format passes data and metadata untouched
// - write, action flag 0: sizes kept, field checked in flight
// - failed check ends command with guard, app or ref status
// - write, action 1, eight-byte metadata: generate and append field
// - write, action 1, larger metadata: overwrite field with generated
// - read, action flag 0: sizes kept, field checked in flight
// - read, action 1, eight-byte metadata: check then strip field
// - read, action 1, larger metadata: check, pass field unaltered
// - guard compared only when check select bit 2 is set
// - check select bit 1: compare app tag where mask bit is one
// - ref tag from initial value, +1 per block types 1-2, fixed type 3
// - skip all checks on app tag all ones (type 3: both tags all ones)
package e2e_pkg;

  // ----------------------------------------------------------------
  // sizes, crc and register map
  // ----------------------------------------------------------------
  localparam logic [15:0] BLK_LEN = 16'h0200;
  localparam logic [15:0] PI_LEN = 16'h0008;
  localparam logic [15:0] CRC_POLY = 16'h8BB7;
  localparam logic [15:0] CRC_INIT = 16'h0000;
  localparam logic [15:0] APP_ALL1 = 16'hFFFF;
  localparam logic [31:0] REF_ALL1 = 32'hFFFFFFFF;
  localparam logic [1:0] PT_NONE = 2'h0;
  localparam logic [1:0] PT_TYPE3 = 2'h3;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_FMT = 8'h04;
  localparam logic [7:0] OFS_TAGS = 8'h08;
  localparam logic [7:0] OFS_REF = 8'h0C;
  localparam logic [7:0] OFS_COUNT = 8'h10;
  localparam logic [7:0] OFS_STAT = 8'h14;
  localparam logic [7:0] OFS_CURREF = 8'h18;
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_WR_BIT = 1;
  localparam int CTRL_ACT_BIT = 2;
  localparam int CTRL_CHK_LSB = 3;
  localparam int FMT_TYPE_LSB = 0;
  localparam int FMT_PIFIRST_BIT = 2;
  localparam int FMT_SEP_BIT = 3;
  localparam int FMT_MD_LSB = 8;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_ERR_LSB = 2;
  localparam int STAT_LEFT_LSB = 16;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    E2E_IDLE = 2'b00, E2E_RUN = 2'b01, E2E_DRAIN = 2'b11, E2E_DONE = 2'b10
  } e2e_state_t;
  typedef enum logic [1:0] {
    ERR_NONE = 2'h0, ERR_GUARD = 2'h1, ERR_APP = 2'h2, ERR_REF = 2'h3
  } e2e_err_t;
  typedef struct packed {
    logic meta;
    logic [7:0] data;
  } e2e_byte_t;
  typedef struct packed {
    logic [1:0] ptype;
    logic pi_first;
    logic sep;
    logic [7:0] md;
    logic wr;
    logic act;
    logic [2:0] chk;
    logic [15:0] app;
    logic [15:0] mask;
    logic [31:0] ref0;
    logic [15:0] nblk;
  } e2e_cfg_t;
  typedef struct packed {
    e2e_state_t st;
    e2e_cfg_t cfg;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [15:0] pos;
    logic [15:0] left;
    logic [31:0] refx;
    logic [15:0] crc;
    logic [55:0] pi_sh;
    e2e_err_t err;
    logic done;
    logic ovalid;
    e2e_byte_t obyte;
  } e2e_st_t;
  localparam e2e_st_t ST_RST = '0;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // all-ones tags switch checking off for the whole field
  function automatic logic pi_skip(input logic [1:0] t,
                                   input logic [15:0] a,
                                   input logic [31:0] r);
    if (t == PT_TYPE3) begin
      return (a == APP_ALL1) && (r == REF_ALL1);
    end
    return a == APP_ALL1;
  endfunction

  // byte-lane merge for axi write strobes
  function automatic logic [31:0] wr32(input logic [31:0] old_w,
                                       input logic [31:0] new_w,
                                       input logic [3:0] strb);
    logic [31:0] w;
    w = old_w;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        w[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return w;
  endfunction

  function automatic logic addr_ok(input logic [7:0] a);
    return a inside {OFS_CTRL, OFS_FMT, OFS_TAGS, OFS_REF, OFS_COUNT,
                     OFS_STAT, OFS_CURREF};
  endfunction

endpackage

// ===== hdl/e2e_crc16_step.sv
// one-byte step of the guard crc
`timescale 1ns/1ps
module e2e_crc16_step
  import e2e_pkg::*;
(
  input wire logic [15:0] crc_i,
  input wire logic [7:0] data_i,
  output logic [15:0] crc_o
);

  // ----------------------------------------------------------------
  // bit-serial loop, msb first, no final inversion
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] c;
    logic fb;
    c = crc_i;
    fb = 1'b0;
    for (int i = 7; i >= 0; i--) begin
      fb = c[15] ^ data_i[i];
      c = {c[14:0], 1'b0};
      if (fb) begin
        c = c ^ CRC_POLY;
      end
    end
    crc_o = c;
  end

endmodule

// ===== sim/e2e_media_model.sv
// media and host buffer model: byte source and stalling byte sink
`timescale 1ns/1ps
module e2e_media_model (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic slow_i,
  output logic in_valid_o,
  input wire logic in_ready_i,
  output logic [7:0] in_data_o,
  input wire logic out_valid_i,
  output logic out_ready_o,
  input wire logic [7:0] out_data_i
);
  logic [7:0] src [0:1055];
  logic [7:0] snk [0:1055];
  logic [7:0] last = 8'h00;
  int n_src, n_in, n_out, cnt;

  // extended blocks: data then metadata in one stream
  assign in_valid_o = n_in < n_src;
  // idle line shows the inverse so a stale byte never passes for data
  assign in_data_o = in_valid_o ? src[n_in] : ~last;
  // slow sink refuses two cycles in four
  assign out_ready_o = !slow_i || cnt[1];

  // counters and capture
  always @(posedge clk_i) begin
    cnt <= cnt + 1;
    if (clr_i) begin
      n_in <= 0;
      n_out <= 0;
    end else begin
      if (in_valid_o && in_ready_i) begin
        last <= src[n_in];
        n_in <= n_in + 1;
      end
      if (out_valid_i && out_ready_o) begin
        snk[n_out] <= out_data_i;
        n_out <= n_out + 1;
      end
    end
  end
endmodule

// ===== sim/tb_end_to_end_protection_engine.sv
// testbench of the protection field engine
`timescale 1ns/1ps
module tb_end_to_end_protection_engine import e2e_pkg::*;;
  localparam logic [15:0] APP = 16'h1234;
  localparam logic [15:0] MSK = 16'hFEFF;
  localparam logic [31:0] REF0 = 32'h00A0_0010;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  logic clr = 1'b0, slow = 1'b0;
  logic [7:0] awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic awr, wrdy, bv, arr, rv, iv, ir, im, ov, ory, om, busy;
  logic [1:0] br, rr;
  logic [7:0] idat, odat;
  logic [7:0] ex [0:1055];
  int nex, errors, total_checks;

  e2e_engine i_dut (.CLK_I(clk), .NRST_I(nrst), .CE_I(1'b1),
    .S_AXI_AWVALID(awv), .S_AXI_AWREADY(awr), .S_AXI_AWADDR(awa),
    .S_AXI_WVALID(wv), .S_AXI_WREADY(wrdy), .S_AXI_WDATA(wd),
    .S_AXI_WSTRB(4'hF), .S_AXI_BVALID(bv), .S_AXI_BREADY(bry),
    .S_AXI_BRESP(br), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr),
    .S_AXI_ARADDR(ara), .S_AXI_RVALID(rv), .S_AXI_RREADY(rry),
    .S_AXI_RDATA(rd), .S_AXI_RRESP(rr), .IN_VALID_I(iv),
    .IN_READY_O(ir), .IN_DATA_I(idat), .IN_META_O(im),
    .OUT_VALID_O(ov), .OUT_READY_I(ory), .OUT_DATA_O(odat),
    .OUT_META_O(om), .BUSY_O(busy));
  e2e_media_model i_med (.clk_i(clk), .clr_i(clr), .slow_i(slow),
    .in_valid_o(iv), .in_ready_i(ir), .in_data_o(idat),
    .out_valid_i(ov), .out_ready_o(ory), .out_data_i(odat));

  // 125 MHz clock
  initial begin
    forever #4 clk = ~clk;
  end

  // ------------------------------------------------------------
  // report, bus and reference helpers
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      errors++;
      $display("unexpected %s exp %0h got %0h", nm, e, g);
    end
  endtask

  task automatic tmo();
    chk("handshake timeout", 32'h0, 32'h1);
    finish_test();
  endtask

  // readiness sampled at the low phase, settled before the edge
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ha, hw, hb;
    logic [1:0] r;
    hb = 1'b0;
    @(posedge clk);
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    for (int n = 0; n < 50 && !hb; n++) begin
      @(negedge clk);
      ha = awv && awr;
      hw = wv && wrdy;
      hb = bv;
      r = br;
      @(posedge clk);
      if (ha) awv <= 1'b0;
      if (hw) wv <= 1'b0;
      if (hb) bry <= 1'b0;
    end
    if (!hb) tmo();
    chk("write response", 32'(RESP_OKAY), 32'(r));
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    logic ha, hr;
    hr = 1'b0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    for (int n = 0; n < 50 && !hr; n++) begin
      @(negedge clk);
      ha = arv && arr;
      hr = rv;
      d = rd;
      r = rr;
      @(posedge clk);
      if (ha) arv <= 1'b0;
      if (hr) rry <= 1'b0;
    end
    if (!hr) tmo();
  endtask

  // bitwise guard reference, msb first, zero seed
  function automatic logic [15:0] crc8(input logic [15:0] c,
                                       input logic [7:0] b);
    c = c ^ {b, 8'h00};
    for (int i = 0; i < 8; i++) begin
      c = c[15] ? ({c[14:0], 1'b0} ^ CRC_POLY) : {c[14:0], 1'b0};
    end
    return c;
  endfunction

  // two-block command; ci picks a field byte to corrupt, 8 for none
  task automatic run(input logic w, input logic a, input logic [7:0] md,
      input logic pf, input logic [1:0] t, input logic [2:0] ck,
      input logic [15:0] fa, input int ci, input logic [1:0] ee);
    logic [15:0] c;
    logic [63:0] f, g;
    logic [31:0] s, rf;
    logic [7:0] v, gv;
    logic [1:0] r;
    int fo, ns, k;
    fo = pf ? 0 : md - 8;
    ns = 0;
    nex = 0;
    for (int b = 0; b < 2; b++) begin
      c = CRC_INIT;
      for (int i = 0; i < 512 + md; i++) begin
        k = i - 512;
        v = (i < 512) ? 8'(i + 3 * b) : 8'(k + 192);
        if (i < 512 || k < fo) c = crc8(c, v);
      end
      rf = (t == 2'h3) ? REF0 : REF0 + 32'(b);
      f = {c, fa, rf};
      g = {c, APP, rf};
      if (ci < 8) f[63 - 8 * ci] = ~f[63 - 8 * ci];
      for (int i = 0; i < 512 + md; i++) begin
        k = i - 512;
        v = (i < 512) ? 8'(i + 3 * b) : 8'(k + 192);
        gv = v;
        if (k >= fo && k < fo + 8) begin
          v = f[63 - 8 * (k - fo) -: 8];
          gv = g[63 - 8 * (k - fo) -: 8];
        end
        if (i < 512 || !(w && a && md == 8'h08)) begin
          i_med.src[ns] = v;
          ns++;
        end
        if (i < 512 || !(!w && a && md == 8'h08)) begin
          ex[nex] = (w && a) ? gv : v;
          nex++;
        end
      end
    end
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    i_med.n_src = ns;
    axw(OFS_FMT, {16'h0, md, 4'h0, 1'b0, pf, t});
    axw(OFS_TAGS, {MSK, APP});
    axw(OFS_REF, REF0);
    axw(OFS_COUNT, 32'h0000_0002);
    axw(OFS_CTRL, {26'h0, ck, a, w, 1'b1});
    s = 32'h0;
    for (int n = 0; n < 2000 && !(s[1] && !s[0]); n++) begin
      axr(OFS_STAT, s, r);
    end
    if (!s[1]) tmo();
    chk("error code", 32'(ee), 32'(s[3:2]));
    chk("blocks left", 32'h0, 32'(s[31:16]));
    chk("bytes taken", 32'(ns), 32'(i_med.n_in));
    chk("bytes out", 32'(nex), 32'(i_med.n_out));
    chk("busy after done", 32'h0, 32'(busy));
    chk("out meta flag", 32'h0, 32'(om));
    chk("in meta flag", 32'h0, 32'(im));
    for (int i = 0; i < nex; i++) begin
      chk("out byte", 32'(ex[i]), 32'(i_med.snk[i]));
    end
    $display("test done wr %0d act %0d md %0d", w, a, md);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] s;
    logic [1:0] r;
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (3) @(posedge clk);
    axr(8'h40, s, r);
    chk("unmapped resp", 32'(RESP_SLVERR), 32'(r));
    chk("unmapped data", 32'h0, s);
    run(1, 1, 8'h08, 0, 2'h1, 3'h7, APP, 8, 2'h0);
    run(1, 1, 8'h10, 1, 2'h1, 3'h7, APP, 0, 2'h0);
    run(0, 0, 8'h10, 0, 2'h1, 3'h7, APP, 8, 2'h0);
    run(0, 1, 8'h08, 0, 2'h1, 3'h7, APP, 8, 2'h0);
    slow <= 1'b1;
    run(0, 1, 8'h10, 1, 2'h1, 3'h7, APP, 2, 2'h2);
    run(1, 0, 8'h08, 0, 2'h1, 3'h7, APP, 0, 2'h1);
    run(0, 0, 8'h08, 0, 2'h1, 3'h7, APP, 4, 2'h3);
    run(0, 0, 8'h08, 0, 2'h1, 3'h3, APP, 0, 2'h0);
    run(0, 0, 8'h08, 0, 2'h1, 3'h7, APP_ALL1, 0, 2'h0);
    run(0, 0, 8'h08, 0, 2'h3, 3'h1, APP, 8, 2'h0);
    run(0, 0, 8'h08, 0, 2'h3, 3'h7, APP_ALL1, 4, 2'h2);
    run(0, 0, 8'h08, 0, 2'h0, 3'h7, APP, 0, 2'h0);
    run(0, 0, 8'h08, 0, 2'h1, 3'h2, APP ^ 16'h0100, 8, 2'h0);
    axr(OFS_FMT, s, r);
    chk("format type", 32'h1, 32'(s[1:0]));
    finish_test();
  end
endmodule
